/* inc/obcd_regs.vh */
// Constants for the option byte configuration decoder: indices, fields, defaults, commands.
`ifndef OBCD_REGS_VH
`define OBCD_REGS_VH

// Index of each option byte as selected by the programming port.
`define OBCD_OPT0_IDX       1'b0
`define OBCD_OPT1_IDX       1'b1

// Field positions in the clock, supervisor and watchdog byte.
`define OBCD_CLKSRC_HI      7
`define OBCD_CLKSRC_LO      6
`define OBCD_RSVD5_BIT      5
`define OBCD_RSVD4_BIT      4
`define OBCD_RSVD3_BIT      3
`define OBCD_VDET_OFF_BIT   2
`define OBCD_WDOG_SW_BIT    1
`define OBCD_WDOG_HALT_BIT  0

// Field positions in the flash protection byte.
`define OBCD_SECT0_HI       3
`define OBCD_SECT0_LO       2
`define OBCD_RDPROT_BIT     1
`define OBCD_WRLOCK_BIT     0

// Shipped and erased values of the option bytes and of program memory.
`define OBCD_OPT0_DFLT      8'hf0
`define OBCD_OPT1_DFLT      8'h2f
`define OBCD_ERASED         8'hff
`define OBCD_ZERO_BYTE      8'h00

// Start-up clock source codes.
`define OBCD_CLK_INT_RC     2'h0
`define OBCD_CLK_WAKE_LF    2'h1
`define OBCD_CLK_RESERVED   2'h2
`define OBCD_CLK_EXT_PIN    2'h3

// Sector 0 size codes and the resulting sizes in bytes.
`define OBCD_SECT0_HALF     2'h0
`define OBCD_SECT0_ONE      2'h2
`define OBCD_SECT0_B_HALF   12'h200
`define OBCD_SECT0_B_ONE    12'h400
`define OBCD_SECT0_B_TWO    12'h800

// Programming port command codes.
`define OBCD_OP_OPT_RD      3'h0
`define OBCD_OP_OPT_WR      3'h1
`define OBCD_OP_OPT_ERASE   3'h2
`define OBCD_OP_MEM_RD      3'h3
`define OBCD_OP_MEM_WR      3'h4
`define OBCD_OP_MEM_ERASE   3'h5

`endif

/* logic/obcd_nv_store.v */
// Non-volatile cells: program memory array and the two option bytes.
`timescale 1ns/10ps
`default_nettype none
`include "obcd_regs.vh"

module obcd_nv_store #(
  parameter MEM_AW    = 11,   // Program memory address width.
  parameter MEM_DEPTH = 2048  // Program memory size in bytes.
) (
  input  wire              clk,         // Core clock.
  input  wire              mem_we,      // Program memory write strobe.
  input  wire [MEM_AW-1:0] mem_addr,    // Program memory address.
  input  wire [7:0]        mem_wdata,   // Program memory write data.
  output reg  [7:0]        mem_rdata,   // Registered program memory read data.
  input  wire              opt0_we,     // Flash protection byte write strobe.
  input  wire [7:0]        opt0_wdata,  // Flash protection byte write data.
  input  wire              opt1_we,     // Clock and watchdog byte write strobe.
  input  wire [7:0]        opt1_wdata,  // Clock and watchdog byte write data.
  output reg  [7:0]        opt0_q,      // Flash protection byte contents.
  output reg  [7:0]        opt1_q       // Clock and watchdog byte contents.
);

  // Program memory cells.
  reg [7:0] mem [0:MEM_DEPTH-1];
  integer   i;

  // These cells model non-volatile storage, so reset never touches them.
  // Their only starting point is the factory state given here.
  initial begin
    for (i = 0; i < MEM_DEPTH; i = i + 1) begin
      mem[i] = `OBCD_ERASED;
    end
    opt0_q    = `OBCD_OPT0_DFLT;
    opt1_q    = `OBCD_OPT1_DFLT;
    mem_rdata = `OBCD_ZERO_BYTE;
  end

  // Memory write and synchronous read; read data appears one edge later.
  always @(posedge clk) begin
    if (mem_we) begin
      mem[mem_addr] <= mem_wdata;
    end
    mem_rdata <= mem[mem_addr];
  end

  // Option byte cells.
  always @(posedge clk) begin
    if (opt0_we) begin
      opt0_q <= opt0_wdata;
    end
    if (opt1_we) begin
      opt1_q <= opt1_wdata;
    end
  end

endmodule
`default_nettype wire

/* logic/obcd_option_byte_config_decode.v */
// Option byte store, programming-mode access port and static configuration decode.
`timescale 1ns/10ps
`default_nettype none
`include "obcd_regs.vh"

// How it works
// - Option bytes reachable only in programming mode.
// - Byte 1 bits 7:6 pick start-up clock.
// - Codes: internal RC, wake-up RC, reserved, external.
// - Byte 1 bit 2 zero enables voltage detector.
// - Byte 1 bit 1: hardware or software watchdog.
// - Byte 1 bit 0: reset when halting watchdog.
// - Byte 0 bits 3:2 set sector 0 size.
// - Read-out protection blocks reads and flash writes.
// - Erasing options under protection erases memory first.
// - Byte 0 bit 0 marks memory write protected.
// - Write protection permanently refuses memory, bit changes.
// - Program memory ships erased to all ones.
module obcd_option_byte_config_decode #(
  parameter MEM_AW    = 11,   // Program memory address width.
  parameter MEM_DEPTH = 2048  // Program memory size in bytes.
) (
  input  wire              clk,                        // Core clock, 125 MHz.
  input  wire              reset,                      // Synchronous reset, active high.
  input  wire              prog_mode_pin,              // Programming mode level from pin.
  input  wire              prog_req,                   // One-cycle command strobe.
  input  wire [2:0]        prog_op,                    // Command code.
  input  wire              prog_sel,                   // Option byte index.
  input  wire [MEM_AW-1:0] prog_addr,                  // Program memory address.
  input  wire [7:0]        prog_wdata,                 // Write data.
  output reg               prog_ack,                   // One-cycle completion pulse.
  output reg               prog_err,                   // Refusal flag, valid with ack.
  output reg  [7:0]        prog_rdata,                 // Read data, valid with ack.
  output reg               prog_busy,                  // Command in progress.
  output reg  [1:0]        startup_clock_select,       // Raw start-up clock code.
  output reg               clk_internal_rc_sel,        // Start on internal RC.
  output reg               clk_wakeup_lf_sel,          // Start on wake-up low-frequency RC.
  output reg               clk_external_pin_sel,       // Start on external clock pin.
  output reg               clk_select_reserved,        // Reserved code was programmed.
  output reg               low_voltage_detect_disable, // Voltage detector switched off.
  output reg               voltage_detector_enable,    // Voltage detector switched on.
  output reg               watchdog_software_type,     // Watchdog waits for firmware.
  output reg               watchdog_hw_always_on,      // Watchdog runs from reset.
  output reg               watchdog_reset_on_halt,     // Halt with watchdog resets.
  output reg  [1:0]        sector_zero_size,           // Raw sector 0 size code.
  output reg  [11:0]       sector_zero_bytes,          // Sector 0 size in bytes.
  output reg               readout_protect,            // Read-out protection active.
  output reg               write_protect_lock,         // Write protection active.
  output reg               app_flash_write_block       // Application flash writes barred.
);

  // Sequencer states.
  localparam [1:0] S_IDLE  = 2'h0;  // Waiting for a command.
  localparam [1:0] S_MREAD = 2'h1;  // Waiting for memory read data.
  localparam [1:0] S_ERASE = 2'h2;  // Walking the memory with erased bytes.

  localparam [MEM_AW-1:0] LAST_ADDR = MEM_DEPTH[MEM_AW-1:0] - {{(MEM_AW-1){1'b0}}, 1'b1}; // Last.

  // Pin synchroniser for the programming mode level.
  reg              pmode_meta_r;   // First stage, read only by the second.
  reg              pmode_sync_r;   // Settled programming mode level.

  // Sequencer state.
  reg  [1:0]        state_r;       // Current state.
  reg  [MEM_AW-1:0] erase_addr_r;  // Next address to erase.
  reg               erase_opts_r;  // Option bytes follow the memory erase.

  // Store strobes, built combinationally.
  reg              mem_we;        // Memory write strobe.
  reg [MEM_AW-1:0] mem_addr;      // Memory address.
  reg [7:0]        mem_wdata;     // Memory write data.
  reg              opt0_we;       // Protection byte write strobe.
  reg [7:0]        opt0_wdata;    // Protection byte write data.
  reg              opt1_we;       // Clock and watchdog byte write strobe.
  reg [7:0]        opt1_wdata;    // Clock and watchdog byte write data.

  // Store outputs.
  wire [7:0]       mem_rdata;     // Registered memory read data.
  wire [7:0]       opt0_q;        // Live protection byte.
  wire [7:0]       opt1_q;        // Live clock and watchdog byte.

  // Live protection state drives the programming path, not the reset copy,
  // so a lock set in this session is honoured at once.
  wire live_rdprot = opt0_q[`OBCD_RDPROT_BIT];   // Live read-out protection.
  wire live_wrlock = opt0_q[`OBCD_WRLOCK_BIT];   // Live write protection.

  // A command is taken only when idle and the settled mode level is high.
  wire cmd_take    = prog_req & pmode_sync_r & (state_r == S_IDLE);
  wire cmd_refused;                               // Taken command is refused.

  // Decides whether a command must be refused given the live protection state.
  function obcd_refuse;
    input [2:0] op;
    input       sel;
    input [7:0] wdata;
    input       rdprot;
    input       wrlock;
    begin
      case (op)
        `OBCD_OP_OPT_RD:    obcd_refuse = 1'b0;
        // The lock bit itself may never change once set, and read-out
        // protection is only lifted by an option erase.
        `OBCD_OP_OPT_WR:    obcd_refuse = (sel == `OBCD_OPT0_IDX) &
                                          (wrlock | (rdprot & ~wdata[`OBCD_RDPROT_BIT]));
        `OBCD_OP_OPT_ERASE: obcd_refuse = wrlock;
        `OBCD_OP_MEM_RD:    obcd_refuse = rdprot;
        `OBCD_OP_MEM_WR:    obcd_refuse = rdprot | wrlock;
        `OBCD_OP_MEM_ERASE: obcd_refuse = rdprot | wrlock;
        default:            obcd_refuse = 1'b1;
      endcase
    end
  endfunction

  // Converts a sector 0 code into its size in bytes.
  function [11:0] obcd_sect0_bytes;
    input [1:0] code;
    begin
      if (code[0]) begin
        obcd_sect0_bytes = `OBCD_SECT0_B_TWO;
      end else if (code == `OBCD_SECT0_ONE) begin
        obcd_sect0_bytes = `OBCD_SECT0_B_ONE;
      end else begin
        obcd_sect0_bytes = `OBCD_SECT0_B_HALF;
      end
    end
  endfunction

  assign cmd_refused = obcd_refuse(prog_op, prog_sel, prog_wdata, live_rdprot, live_wrlock);

  // Non-volatile cells.
  obcd_nv_store #(
    .MEM_AW    (MEM_AW),
    .MEM_DEPTH (MEM_DEPTH)
  ) u_store (
    .clk        (clk),
    .mem_we     (mem_we),
    .mem_addr   (mem_addr),
    .mem_wdata  (mem_wdata),
    .mem_rdata  (mem_rdata),
    .opt0_we    (opt0_we),
    .opt0_wdata (opt0_wdata),
    .opt1_we    (opt1_we),
    .opt1_wdata (opt1_wdata),
    .opt0_q     (opt0_q),
    .opt1_q     (opt1_q)
  );

  // Two-stage synchroniser for the programming mode pin.
  always @(posedge clk) begin
    if (reset) begin
      pmode_meta_r <= 1'b0;
      pmode_sync_r <= 1'b0;
    end else begin
      pmode_meta_r <= prog_mode_pin;
      pmode_sync_r <= pmode_meta_r;
    end
  end

  // Store write strobes. Writes are held off during reset so a command
  // racing the reset cannot corrupt the non-volatile cells.
  always @* begin
    mem_we     = 1'b0;
    mem_addr   = prog_addr;
    mem_wdata  = prog_wdata;
    opt0_we    = 1'b0;
    opt0_wdata = prog_wdata;
    opt1_we    = 1'b0;
    opt1_wdata = prog_wdata;
    if (!reset) begin
      case (state_r)
        S_IDLE: begin
          if (cmd_take && !cmd_refused) begin
            case (prog_op)
              `OBCD_OP_OPT_WR: begin
                // The tool keeps the reserved bits at their fixed values.
                opt0_we = (prog_sel == `OBCD_OPT0_IDX);
                opt1_we = (prog_sel == `OBCD_OPT1_IDX);
              end
              `OBCD_OP_OPT_ERASE: begin
                // Without read-out protection the bytes return to defaults now.
                opt0_we    = !live_rdprot;
                opt1_we    = !live_rdprot;
                opt0_wdata = `OBCD_OPT0_DFLT;
                opt1_wdata = `OBCD_OPT1_DFLT;
              end
              `OBCD_OP_MEM_WR: begin
                mem_we = 1'b1;
              end
              default: begin
                mem_we = 1'b0;
              end
            endcase
          end
        end
        S_ERASE: begin
          mem_we    = 1'b1;
          mem_addr  = erase_addr_r;
          mem_wdata = `OBCD_ERASED;
          if (erase_addr_r == LAST_ADDR && erase_opts_r) begin
            opt0_we    = 1'b1;
            opt1_we    = 1'b1;
            opt0_wdata = `OBCD_OPT0_DFLT;
            opt1_wdata = `OBCD_OPT1_DFLT;
          end
        end
        default: begin
          mem_we = 1'b0;
        end
      endcase
    end
  end

  // Command sequencer and answer registers.
  always @(posedge clk) begin
    if (reset) begin
      state_r      <= S_IDLE;
      erase_addr_r <= {MEM_AW{1'b0}};
      erase_opts_r <= 1'b0;
      prog_ack     <= 1'b0;
      prog_err     <= 1'b0;
      prog_rdata   <= `OBCD_ZERO_BYTE;
      prog_busy    <= 1'b0;
    end else begin
      prog_ack <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (cmd_take) begin
            if (cmd_refused) begin
              prog_ack   <= 1'b1;
              prog_err   <= 1'b1;
              prog_rdata <= `OBCD_ZERO_BYTE;
            end else if (prog_op == `OBCD_OP_MEM_RD) begin
              prog_busy <= 1'b1;
              state_r   <= S_MREAD;
            end else if (prog_op == `OBCD_OP_MEM_ERASE ||
                         (prog_op == `OBCD_OP_OPT_ERASE && live_rdprot)) begin
              erase_opts_r <= (prog_op == `OBCD_OP_OPT_ERASE);
              erase_addr_r <= {MEM_AW{1'b0}};
              prog_busy    <= 1'b1;
              state_r      <= S_ERASE;
            end else begin
              // Option reads answer from the live byte; writes just complete.
              prog_ack   <= 1'b1;
              prog_err   <= 1'b0;
              prog_rdata <= (prog_op != `OBCD_OP_OPT_RD) ? `OBCD_ZERO_BYTE :
                            (prog_sel == `OBCD_OPT0_IDX) ? opt0_q : opt1_q;
            end
          end
        end
        S_MREAD: begin
          // The store's read data is ready one edge after the address.
          prog_ack   <= 1'b1;
          prog_err   <= 1'b0;
          prog_rdata <= mem_rdata;
          prog_busy  <= 1'b0;
          state_r    <= S_IDLE;
        end
        S_ERASE: begin
          if (erase_addr_r == LAST_ADDR) begin
            prog_ack     <= 1'b1;
            prog_err     <= 1'b0;
            prog_rdata   <= `OBCD_ZERO_BYTE;
            prog_busy    <= 1'b0;
            erase_opts_r <= 1'b0;
            state_r      <= S_IDLE;
          end else begin
            erase_addr_r <= erase_addr_r + {{(MEM_AW-1){1'b0}}, 1'b1};
          end
        end
        default: begin
          state_r   <= S_IDLE;
          prog_busy <= 1'b0;
        end
      endcase
    end
  end

  // Decoded configuration. The fields follow the option bytes only while
  // reset is high; afterwards they stay frozen, so reprogramming takes
  // effect at the next reset and the clock and watchdog never see a glitch.
  always @(posedge clk) begin
    if (reset) begin
      startup_clock_select <= opt1_q[`OBCD_CLKSRC_HI:`OBCD_CLKSRC_LO];
      // Decode clock codes.
      // The reserved code falls back to the internal RC so the core still starts.
      clk_internal_rc_sel  <=
        (opt1_q[`OBCD_CLKSRC_HI:`OBCD_CLKSRC_LO] == `OBCD_CLK_INT_RC) |
        (opt1_q[`OBCD_CLKSRC_HI:`OBCD_CLKSRC_LO] == `OBCD_CLK_RESERVED);
      clk_wakeup_lf_sel    <=
        (opt1_q[`OBCD_CLKSRC_HI:`OBCD_CLKSRC_LO] == `OBCD_CLK_WAKE_LF);
      clk_external_pin_sel <=
        (opt1_q[`OBCD_CLKSRC_HI:`OBCD_CLKSRC_LO] == `OBCD_CLK_EXT_PIN);
      clk_select_reserved  <=
        (opt1_q[`OBCD_CLKSRC_HI:`OBCD_CLKSRC_LO] == `OBCD_CLK_RESERVED);
      low_voltage_detect_disable <= opt1_q[`OBCD_VDET_OFF_BIT];
      voltage_detector_enable    <= ~opt1_q[`OBCD_VDET_OFF_BIT];
      watchdog_software_type <= opt1_q[`OBCD_WDOG_SW_BIT];
      watchdog_hw_always_on  <= ~opt1_q[`OBCD_WDOG_SW_BIT];
      watchdog_reset_on_halt <= opt1_q[`OBCD_WDOG_HALT_BIT];
      sector_zero_size  <= opt0_q[`OBCD_SECT0_HI:`OBCD_SECT0_LO];
      sector_zero_bytes <= obcd_sect0_bytes(opt0_q[`OBCD_SECT0_HI:`OBCD_SECT0_LO]);
      readout_protect <= opt0_q[`OBCD_RDPROT_BIT];
      write_protect_lock <= opt0_q[`OBCD_WRLOCK_BIT];
      app_flash_write_block <= opt0_q[`OBCD_RDPROT_BIT] | opt0_q[`OBCD_WRLOCK_BIT];
    end
  end

endmodule
`default_nettype wire

/* verification/obcd_checker_properties.sv */
// Port checker for the option byte decoder.
`timescale 1ns/10ps
`default_nettype none
module obcd_checker (
  input wire logic        clk,                        // Clock.
  input wire logic        reset,                      // Reset.
  input wire logic        prog_mode_pin,              // Mode pin.
  input wire logic        prog_ack,                   // Answer.
  input wire logic        prog_err,                   // Refusal.
  input wire logic [7:0]  prog_rdata,                 // Read data.
  input wire logic        prog_busy,                  // Busy.
  input wire logic [1:0]  startup_clock_select,       // Clock code.
  input wire logic        clk_internal_rc_sel,        // Internal RC.
  input wire logic        clk_wakeup_lf_sel,          // Wake-up RC.
  input wire logic        clk_external_pin_sel,       // External pin.
  input wire logic        clk_select_reserved,        // Reserved code.
  input wire logic        low_voltage_detect_disable, // Detector off.
  input wire logic        voltage_detector_enable,    // Detector on.
  input wire logic        watchdog_software_type,     // Soft watchdog.
  input wire logic        watchdog_hw_always_on,      // Hard watchdog.
  input wire logic        watchdog_reset_on_halt,     // Halt reset.
  input wire logic [1:0]  sector_zero_size,           // Sector code.
  input wire logic [11:0] sector_zero_bytes,          // Sector bytes.
  input wire logic        readout_protect,            // Read-out lock.
  input wire logic        write_protect_lock,         // Write lock.
  input wire logic        app_flash_write_block       // Writes barred.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_dec_hold;
    !$past(reset) |-> $stable({startup_clock_select, sector_zero_size, readout_protect,
      write_protect_lock, low_voltage_detect_disable, watchdog_software_type,
      watchdog_reset_on_halt});
  endproperty
  a_dec_hold: assert property (p_dec_hold) else $error("decode moved after reset");
  property p_rc_sel;
    clk_internal_rc_sel == !startup_clock_select[0];
  endproperty
  a_rc_sel: assert property (p_rc_sel) else $error("internal RC select wrong");
  property p_clk_map;
    $onehot({clk_internal_rc_sel, clk_wakeup_lf_sel, clk_external_pin_sel})
      && clk_select_reserved == (startup_clock_select == 2'h2)
      && clk_external_pin_sel == (startup_clock_select == 2'h3);
  endproperty
  a_clk_map: assert property (p_clk_map) else $error("clock decode wrong");
  property p_lvd;
    voltage_detector_enable != low_voltage_detect_disable;
  endproperty
  a_lvd: assert property (p_lvd) else $error("detector enable wrong");
  property p_wdg;
    watchdog_hw_always_on != watchdog_software_type;
  endproperty
  a_wdg: assert property (p_wdg) else $error("watchdog type wrong");
  property p_sect;
    sector_zero_bytes == (sector_zero_size[0] ? 12'h800 :
                          (sector_zero_size[1] ? 12'h400 : 12'h200));
  endproperty
  a_sect: assert property (p_sect) else $error("sector size wrong");
  property p_block;
    app_flash_write_block == (readout_protect || write_protect_lock);
  endproperty
  a_block: assert property (p_block) else $error("flash write bar wrong");
  property p_mode;
    prog_ack |-> ($past(prog_mode_pin, 3) || $past(prog_mode_pin, 4)
                  || $past(prog_mode_pin, 5) || $past(prog_busy));
  endproperty
  a_mode: assert property (p_mode) else $error("answer outside programming mode");
  property p_busy_end;
    $fell(prog_busy) |-> prog_ack;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy fell without answer");
  property p_refuse;
    prog_ack && prog_err |-> prog_rdata == 8'h00;
  endproperty
  a_refuse: assert property (p_refuse) else $error("refusal leaked data");
endmodule
bind obcd_option_byte_config_decode obcd_checker u_chk (.clk, .reset, .prog_mode_pin,
  .prog_ack, .prog_err, .prog_rdata, .prog_busy, .startup_clock_select, .clk_internal_rc_sel,
  .clk_wakeup_lf_sel, .clk_external_pin_sel, .clk_select_reserved, .low_voltage_detect_disable,
  .voltage_detector_enable, .watchdog_software_type, .watchdog_hw_always_on,
  .watchdog_reset_on_halt, .sector_zero_size, .sector_zero_bytes, .readout_protect,
  .write_protect_lock, .app_flash_write_block);
`default_nettype wire

/* verification/obcd_prog_tool.sv */
// Behavioural programming tool that drives the decoder's programming port.
`timescale 1ns/10ps
`default_nettype none
module obcd_prog_tool (
  input  wire logic       clk,           // Core clock.
  input  wire logic       prog_ack,      // Completion pulse.
  output var  logic       prog_mode_pin, // Programming mode level.
  output var  logic       prog_req,      // Command strobe.
  output var  logic [2:0] prog_op,       // Command code.
  output var  logic       prog_sel,      // Option byte index.
  output var  logic [3:0] prog_addr,     // Memory address.
  output var  logic [7:0] prog_wdata     // Write data.
);
  // The port is quiet and in programming mode from time zero.
  initial begin
    prog_mode_pin = 1'b1;
    prog_req = 1'b0;
    prog_op = 3'h0;
    prog_sel = 1'b0;
    prog_addr = 4'h0;
    prog_wdata = 8'h00;
  end
  // The mode level only ever moves at a clock edge.
  task set_mode(input logic v);
    @(posedge clk) prog_mode_pin <= v;
  endtask
  // Idle gap, one-cycle strobe, bounded wait for the answer.
  task issue(input logic [2:0] op, input logic sel, input logic [3:0] a,
             input logic [7:0] wd, input integer gap, input integer lim, output logic ok);
    integer k;
    begin
      if (op == 3'h1 && sel) wd[5:3] = 3'b101;
      else if (op == 3'h1) wd[7:4] = 4'hf;
      repeat (gap) @(posedge clk);
      @(posedge clk);
      prog_req <= 1'b1;
      prog_op <= op;
      prog_sel <= sel;
      prog_addr <= a;
      prog_wdata <= wd;
      @(posedge clk);
      prog_req <= 1'b0;
      ok = 1'b0;
      for (k = 0; k < lim && !ok; k++) begin
        @(posedge clk);
        ok = (prog_ack === 1'b1);
      end
      // Stale data is inverted so a late sample can never pass by luck.
      prog_addr <= ~a;
      prog_wdata <= ~wd;
    end
  endtask
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// Self-checking bench for the option byte decoder.
`timescale 1ns/10ps
`default_nettype none
`include "obcd_regs.vh"
module tb_top;
  logic        clk;   // Core clock.
  logic        reset; // Synchronous reset.
  wire         prog_mode_pin, prog_req, prog_sel, prog_ack, prog_err, prog_busy;
  wire  [2:0]  prog_op;
  wire  [3:0]  prog_addr;
  wire  [7:0]  prog_wdata, prog_rdata;
  wire  [1:0]  startup_clock_select, sector_zero_size;
  wire  [11:0] sector_zero_bytes;
  wire         clk_internal_rc_sel, clk_wakeup_lf_sel, clk_external_pin_sel, clk_select_reserved;
  wire         low_voltage_detect_disable, voltage_detector_enable, watchdog_software_type;
  wire         watchdog_hw_always_on, watchdog_reset_on_halt, readout_protect;
  wire         write_protect_lock, app_flash_write_block;
  integer      n_mismatch, n_compared, i;
  logic [8:0]  expq[$]; // Expected {refused, read data}, oldest first.
  logic [7:0]  b0, b1;  // Model of the two option bytes.
  logic [7:0]  lf, wv;  // Random state and a saved write value.
  logic        ok;      // Answer seen.
  // A small memory keeps the mass erase short.
  obcd_option_byte_config_decode #(.MEM_AW(4), .MEM_DEPTH(16)) dut (.clk, .reset,
    .prog_mode_pin, .prog_req, .prog_op, .prog_sel, .prog_addr, .prog_wdata, .prog_ack,
    .prog_err, .prog_rdata, .prog_busy, .startup_clock_select, .clk_internal_rc_sel,
    .clk_wakeup_lf_sel, .clk_external_pin_sel, .clk_select_reserved, .low_voltage_detect_disable,
    .voltage_detector_enable, .watchdog_software_type, .watchdog_hw_always_on,
    .watchdog_reset_on_halt, .sector_zero_size, .sector_zero_bytes, .readout_protect,
    .write_protect_lock, .app_flash_write_block);
  obcd_prog_tool tool (.clk, .prog_ack, .prog_mode_pin, .prog_req, .prog_op, .prog_sel,
    .prog_addr, .prog_wdata);
  // Free-running clock, 8 ns period.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  function automatic [7:0] lfsr(input [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task fail(input string m);
    n_mismatch++;
    $display("ERROR %0t %s", $time, m);
  endtask
  task final_report;
    if (n_mismatch == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task cmp_resp(input logic [8:0] e, input logic [8:0] a);
    n_compared++;
    if (a !== e) fail($sformatf("answer exp %h got %h", e, a));
  endtask
  // Decoded outputs against the model bytes, sampled mid-cycle.
  task check_dec;
    logic [27:0] e;
    begin
      @(negedge clk);
      e = {b1[7:6], ~b1[6], b1[7:6] == 2'h1, b1[7:6] == 2'h3, b1[7:6] == 2'h2, b1[2], ~b1[2],
           b1[1], ~b1[1], b1[0], b0[3:2], b0[2] ? `OBCD_SECT0_B_TWO :
           (b0[3] ? `OBCD_SECT0_B_ONE : `OBCD_SECT0_B_HALF), b0[1], b0[0], b0[1] | b0[0]};
      n_compared++;
      if ({startup_clock_select, clk_internal_rc_sel, clk_wakeup_lf_sel, clk_external_pin_sel,
           clk_select_reserved, low_voltage_detect_disable, voltage_detector_enable,
           watchdog_software_type, watchdog_hw_always_on, watchdog_reset_on_halt,
           sector_zero_size, sector_zero_bytes, readout_protect, write_protect_lock,
           app_flash_write_block} !== e) fail($sformatf("decode for %h %h wrong", b0, b1));
    end
  endtask
  // Note the answer, then send the command.
  task cmd(input logic [2:0] op, input logic sel, input logic [3:0] a, input logic [7:0] wd,
           input logic [8:0] e);
    expq.push_back(e);
    lf = lfsr(lf);
    tool.issue(op, sel, a, wd, lf[1:0], 40, ok);
    if (!ok) fail("no answer");
    if (!ok) void'(expq.pop_front());
  endtask
  // Reset pulse of two edges; the bytes are reloaded into the decode.
  task rst;
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // Every answer takes the oldest note off the queue.
  always @(negedge clk) begin
    if (prog_ack === 1'b1) begin
      if (expq.size() == 0) fail("answer without request");
      else cmp_resp(expq.pop_front(), {prog_err, prog_rdata});
    end
  end
  // Cut a hang short.
  initial begin
    #160000;
    fail("timeout");
    final_report;
  end
  initial begin
    n_mismatch = 0;
    n_compared = 0;
    reset = 1'b1;
    b0 = `OBCD_OPT0_DFLT;
    b1 = `OBCD_OPT1_DFLT;
    lf = 8'h0d;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    check_dec;
    tool.set_mode(1'b0);
    repeat (4) @(posedge clk);
    tool.issue(3'h0, 1'b1, 4'h0, 8'h00, 0, 6, ok);
    tool.set_mode(1'b1);
    repeat (4) @(posedge clk);
    cmd(3'h3, 1'b0, 4'h0, 8'h00, 9'h0ff);
    cmd(3'h3, 1'b0, 4'hf, 8'h00, 9'h0ff);
    cmd(3'h6, 1'b0, 4'h0, 8'h00, 9'h100);
    cmd(3'h7, 1'b1, 4'h0, 8'h00, 9'h100);
    for (i = 0; i < 4; i++) begin
      b1 = {i[1:0], 3'b101, lf[2:0]};
      cmd(3'h1, 1'b1, 4'h0, b1, 9'h000);
      cmd(3'h0, 1'b1, 4'h0, 8'h00, {1'b0, b1});
      rst;
      check_dec;
    end
    for (i = 0; i < 4; i++) begin
      b0 = {4'hf, i[1:0], 2'b00};
      cmd(3'h1, 1'b0, 4'h0, b0, 9'h000);
      rst;
      check_dec;
    end
    for (i = 0; i < 3; i++) begin
      wv = lf;
      cmd(3'h4, 1'b0, wv[7:4], wv, 9'h000);
      cmd(3'h3, 1'b0, wv[7:4], 8'h00, {1'b0, wv});
    end
    cmd(3'h5, 1'b0, 4'h0, 8'h00, 9'h000);
    cmd(3'h3, 1'b0, 4'h3, 8'h00, 9'h0ff);
    cmd(3'h4, 1'b0, 4'h5, 8'h5a, 9'h000);
    b0 = 8'hf2;
    cmd(3'h1, 1'b0, 4'h0, b0, 9'h000);
    cmd(3'h3, 1'b0, 4'h5, 8'h00, 9'h100);
    cmd(3'h4, 1'b0, 4'h5, 8'h11, 9'h100);
    cmd(3'h1, 1'b0, 4'h0, 8'hf0, 9'h100);
    rst;
    check_dec;
    cmd(3'h2, 1'b0, 4'h0, 8'h00, 9'h000);
    b0 = `OBCD_OPT0_DFLT;
    b1 = `OBCD_OPT1_DFLT;
    cmd(3'h3, 1'b0, 4'h5, 8'h00, 9'h0ff);
    cmd(3'h0, 1'b0, 4'h0, 8'h00, {1'b0, b0});
    cmd(3'h0, 1'b1, 4'h0, 8'h00, {1'b0, b1});
    b0 = 8'hf1;
    cmd(3'h1, 1'b0, 4'h0, b0, 9'h000);
    cmd(3'h4, 1'b0, 4'h2, 8'h33, 9'h100);
    cmd(3'h5, 1'b0, 4'h0, 8'h00, 9'h100);
    cmd(3'h2, 1'b0, 4'h0, 8'h00, 9'h100);
    cmd(3'h1, 1'b0, 4'h0, 8'hf0, 9'h100);
    b1 = 8'hea;
    cmd(3'h1, 1'b1, 4'h0, b1, 9'h000);
    rst;
    check_dec;
    final_report;
  end
endmodule
`default_nettype wire
